/* rtl/aea_pkg.sv */
// Package with the constants and types of the active energy accumulator.
package aea_pkg;
	// ----------------------------------------------------------------
	// Register map.
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_COMP_MODE = 8'h00;
	localparam logic [7:0] OFS_LINE_MODE = 8'h04;
	localparam logic [7:0] OFS_DIVIDER = 8'h08;
	localparam logic [7:0] OFS_CURR_GAIN = 8'h0c;
	localparam logic [7:0] OFS_GAIN_A = 8'h10;
	localparam logic [7:0] OFS_GAIN_B = 8'h14;
	localparam logic [7:0] OFS_GAIN_C = 8'h18;
	localparam logic [7:0] OFS_ENERGY_A = 8'h1c;
	localparam logic [7:0] OFS_ENERGY_B = 8'h20;
	localparam logic [7:0] OFS_ENERGY_C = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_INT_EN = 8'h2c;
	localparam logic [7:0] OFS_INT_CLR = 8'h30;
	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int COMB_SEL_LSB = 0;
	localparam int COMB_SEL_W = 2;
	localparam int CREEP_GATE_BIT = 7;
	localparam int CLEAR_ON_READ_BIT = 6;
	localparam int HALF_FULL_BIT = 0;
	localparam logic [7:0] COMP_MODE_RST = 8'h00;
	localparam logic [7:0] LINE_MODE_RST = 8'h00;
	localparam logic [7:0] DIVIDER_RST = 8'h00;
	localparam logic [11:0] GAIN_RST = 12'h000;
	// ----------------------------------------------------------------
	// Data path widths and thresholds.
	// ----------------------------------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int POW_W = 36;
	localparam int ACC_W = 41;
	localparam int ENERGY_W = 16;
	localparam int ENERGY_HALF_BIT = 14;
	localparam int DIV_W = 8;
	localparam int GAIN_W = 12;
	localparam int GAIN_SHIFT = 12;
	localparam logic [DIV_W-1:0] DIV_BYPASS_MAX = 8'h01;
	localparam logic [POW_W-1:0] CREEP_LEVEL = 36'h00000002a;
	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int SAMPLE_PERIOD_NS = 400;
	localparam int STEP_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STEP_CNT_W = 2;
	// ----------------------------------------------------------------
	// Types.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {COMB_OWN, COMB_DIFF_BOTH, COMB_DIFF_A, COMB_RESERVED} aea_comb_e;
	typedef struct packed {
		logic signed [SAMPLE_W-1:0] volt;
		logic signed [SAMPLE_W-1:0] curr;
	} aea_phase_s;
endpackage

/* rtl/aea_accumulator.sv */
// One phase of active energy accumulation with divider and creep gate.
`timescale 1ns/1ps
`default_nettype none
module aea_accumulator #(
	parameter int ACC_WIDTH = aea_pkg::ACC_W
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic step_i,
	input wire logic clear_i,
	input wire logic creep_gate_enable_i,
	input wire logic [aea_pkg::DIV_W-1:0] divider_i,
	// Power in, energy out.
	input wire logic signed [aea_pkg::POW_W-1:0] power_i,
	output logic [aea_pkg::ENERGY_W-1:0] energy_o
);
	import aea_pkg::*;

	logic signed [ACC_WIDTH-1:0] acc;
	logic signed [ACC_WIDTH-1:0] term;
	logic [POW_W-1:0] magnitude;
	logic [POW_W-1:0] quotient;
	logic creep;

	// ----------------------------------------------------------------
	// Divide and gate.
	// ----------------------------------------------------------------
	always_comb
	begin
		magnitude = power_i[POW_W-1] ? POW_W'(-power_i) : POW_W'(power_i);
		quotient = (divider_i > DIV_BYPASS_MAX) ? magnitude / POW_W'(divider_i) : magnitude;
		term = power_i[POW_W-1] ? -ACC_WIDTH'(quotient) : ACC_WIDTH'(quotient);
		creep = creep_gate_enable_i && (magnitude < CREEP_LEVEL);
	end

	// ----------------------------------------------------------------
	// Accumulator.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clear_i)
			acc <= '0;
		else if (step_i && !creep)
			acc <= acc + term;
	end

	assign energy_o = acc[ACC_WIDTH-1 -: ENERGY_W];

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	property p_creep_hold;
		@(posedge clk_i) disable iff (rst_i)
		(step_i && !clear_i && creep_gate_enable_i && magnitude < CREEP_LEVEL) |=> acc == $past(acc);
	endproperty
	a_creep_hold: assert property (p_creep_hold) else $error("Gated low power changed energy.");

	property p_gate_off;
		@(posedge clk_i) disable iff (rst_i)
		(step_i && !clear_i && !creep_gate_enable_i) |=> acc == $past(acc) + $past(term);
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("Ungated step did not add.");

	property p_signed_add;
		@(posedge clk_i) disable iff (rst_i)
		(step_i && !clear_i && power_i < 0 && !creep && term != '0) |=>
			acc < $past(acc) || $past(acc[ACC_WIDTH-1]) != acc[ACC_WIDTH-1];
	endproperty
	a_signed_add: assert property (p_signed_add) else $error("Negative power did not decrease energy.");

	property p_clear;
		@(posedge clk_i) disable iff (rst_i)
		clear_i |=> acc == '0 ##1 (energy_o == '0 || $past(step_i));
	endproperty
	a_clear: assert property (p_clear) else $error("Clear on read left energy behind.");

	property p_wrap_up;
		@(posedge clk_i) disable iff (rst_i)
		(step_i && !clear_i && !creep && !power_i[POW_W-1] && !acc[ACC_WIDTH-1]) ##1 acc[ACC_WIDTH-1] |-> energy_o == 16'h8000;
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("Positive overflow did not wrap.");

	property p_no_divide;
		@(posedge clk_i) disable iff (rst_i)
		(divider_i <= DIV_BYPASS_MAX) |-> term == ACC_WIDTH'(power_i);
	endproperty
	a_no_divide: assert property (p_no_divide) else $error("Divider of 0 or 1 changed power.");
endmodule
`default_nettype wire

/* rtl/aea_energy_top.sv */
// Wishbone slave holding three phases of active energy accumulation.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module aea_energy_top (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [aea_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Averaged phase voltage and current.
	input wire aea_pkg::aea_phase_s phase_a_i,
	input wire aea_pkg::aea_phase_s phase_b_i,
	input wire aea_pkg::aea_phase_s phase_c_i,
	// Interrupt.
	output logic irq_n_o
);
	import aea_pkg::*;

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic logic signed [POW_W-1:0] scale(
		input logic signed [POW_W-1:0] v,
		input logic signed [GAIN_W-1:0] g
	);
		logic signed [POW_W+GAIN_W-1:0] prod;
		prod = v * g;
		return v + POW_W'(prod >>> GAIN_SHIFT);
	endfunction

	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0] sel
	);
		logic [15:0] res;
		res = old;
		if (sel[0])
			res[7:0] = dat[7:0];
		if (sel[1])
			res[15:8] = dat[15:8];
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Declarations.
	// ----------------------------------------------------------------
	logic [7:0] computation_mode_reg;
	logic [7:0] line_cycle_mode_reg;
	logic [DIV_W-1:0] energy_power_divider;
	logic [GAIN_W-1:0] current_gain;
	logic [GAIN_W-1:0] power_gain_a;
	logic [GAIN_W-1:0] power_gain_b;
	logic [GAIN_W-1:0] power_gain_c;
	logic half_full_status;
	logic energy_half_full_mask;
	logic [STEP_CNT_W-1:0] step_cnt;
	logic step;
	logic bus_req;
	logic wr;
	logic rd;
	logic [31:0] next_rdata;
	logic signed [POW_W-1:0] power_a;
	logic signed [POW_W-1:0] power_b;
	logic signed [POW_W-1:0] power_c;
	logic signed [POW_W-1:0] next_power_a;
	logic signed [POW_W-1:0] next_power_b;
	logic signed [POW_W-1:0] next_power_c;
	logic signed [POW_W-1:0] cur_a;
	logic signed [POW_W-1:0] cur_b;
	logic signed [POW_W-1:0] cur_c;
	logic signed [POW_W-1:0] sel_a;
	logic signed [POW_W-1:0] sel_c;
	logic keep_b;
	logic keep_all;
	logic [ENERGY_W-1:0] phase_a_active_energy;
	logic [ENERGY_W-1:0] phase_b_active_energy;
	logic [ENERGY_W-1:0] phase_c_active_energy;
	logic [2:0] half_prev;
	logic [2:0] half_now;
	logic half_evt;
	logic clear_on_read_enable;
	logic [2:0] clear_phase;

	// ----------------------------------------------------------------
	// Bus handshake.
	// ----------------------------------------------------------------
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = bus_req && wb_we_i;
	assign rd = bus_req && !wb_we_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req;
	end

	always_comb
	begin
		next_rdata = '0;
		case (wb_adr_i)
			OFS_COMP_MODE: next_rdata = 32'(computation_mode_reg);
			OFS_LINE_MODE: next_rdata = 32'(line_cycle_mode_reg);
			OFS_DIVIDER: next_rdata = 32'(energy_power_divider);
			OFS_CURR_GAIN: next_rdata = 32'(current_gain);
			OFS_GAIN_A: next_rdata = 32'(power_gain_a);
			OFS_GAIN_B: next_rdata = 32'(power_gain_b);
			OFS_GAIN_C: next_rdata = 32'(power_gain_c);
			OFS_ENERGY_A: next_rdata = 32'(phase_a_active_energy);
			OFS_ENERGY_B: next_rdata = 32'(phase_b_active_energy);
			OFS_ENERGY_C: next_rdata = 32'(phase_c_active_energy);
			OFS_STATUS: next_rdata = 32'(half_full_status);
			OFS_INT_EN: next_rdata = 32'(energy_half_full_mask);
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (rd)
			wb_dat_o <= next_rdata;
	end

	// ----------------------------------------------------------------
	// Configuration registers.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			computation_mode_reg <= COMP_MODE_RST;
			line_cycle_mode_reg <= LINE_MODE_RST;
			energy_power_divider <= DIVIDER_RST;
			current_gain <= GAIN_RST;
			power_gain_a <= GAIN_RST;
			power_gain_b <= GAIN_RST;
			power_gain_c <= GAIN_RST;
			energy_half_full_mask <= 1'b0;
		end
		else if (wr)
		begin
			case (wb_adr_i)
				OFS_COMP_MODE: computation_mode_reg <= 8'(merge16(16'(computation_mode_reg), wb_dat_i, wb_sel_i));
				OFS_LINE_MODE: line_cycle_mode_reg <= 8'(merge16(16'(line_cycle_mode_reg), wb_dat_i, wb_sel_i));
				OFS_DIVIDER: energy_power_divider <= 8'(merge16(16'(energy_power_divider), wb_dat_i, wb_sel_i));
				OFS_CURR_GAIN: current_gain <= 12'(merge16(16'(current_gain), wb_dat_i, wb_sel_i));
				OFS_GAIN_A: power_gain_a <= 12'(merge16(16'(power_gain_a), wb_dat_i, wb_sel_i));
				OFS_GAIN_B: power_gain_b <= 12'(merge16(16'(power_gain_b), wb_dat_i, wb_sel_i));
				OFS_GAIN_C: power_gain_c <= 12'(merge16(16'(power_gain_c), wb_dat_i, wb_sel_i));
				OFS_INT_EN:
				begin
					if (wb_sel_i[0])
						energy_half_full_mask <= wb_dat_i[HALF_FULL_BIT];
				end
				default:
				begin
				end
			endcase
		end
	end

	assign clear_on_read_enable = line_cycle_mode_reg[CLEAR_ON_READ_BIT];

	// ----------------------------------------------------------------
	// Sample cadence.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			step_cnt <= '0;
		else
			step_cnt <= step_cnt + STEP_CNT_W'(1);
	end

	assign step = (step_cnt == STEP_CNT_W'(STEP_CYCLES - 1));

	// ----------------------------------------------------------------
	// Phase combination and gains.
	// ----------------------------------------------------------------
	always_comb
	begin
		cur_a = scale(POW_W'(phase_a_i.curr), current_gain);
		cur_b = scale(POW_W'(phase_b_i.curr), current_gain);
		cur_c = scale(POW_W'(phase_c_i.curr), current_gain);
		sel_a = cur_a;
		sel_c = cur_c;
		keep_b = 1'b1;
		keep_all = 1'b1;
		unique case (aea_comb_e'(computation_mode_reg[COMB_SEL_LSB +: COMB_SEL_W]))
			COMB_OWN:
			begin
			end
			COMB_DIFF_BOTH:
			begin
				sel_a = cur_a - cur_b;
				sel_c = cur_c - cur_b;
				keep_b = 1'b0;
			end
			COMB_DIFF_A:
			begin
				sel_a = cur_a - cur_b;
				keep_b = 1'b0;
			end
			COMB_RESERVED:
			begin
				keep_all = 1'b0;
			end
		endcase
		next_power_a = '0;
		next_power_b = '0;
		next_power_c = '0;
		if (keep_all)
		begin
			next_power_a = scale(POW_W'(phase_a_i.volt) * sel_a, power_gain_a);
			next_power_c = scale(POW_W'(phase_c_i.volt) * sel_c, power_gain_c);
			if (keep_b)
				next_power_b = scale(POW_W'(phase_b_i.volt) * cur_b, power_gain_b);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			power_a <= '0;
			power_b <= '0;
			power_c <= '0;
		end
		else
		begin
			power_a <= next_power_a;
			power_b <= next_power_b;
			power_c <= next_power_c;
		end
	end

	// ----------------------------------------------------------------
	// Accumulators.
	// ----------------------------------------------------------------
	always_comb
	begin
		clear_phase = '0;
		if (rd && clear_on_read_enable)
		begin
			clear_phase[0] = (wb_adr_i == OFS_ENERGY_A);
			clear_phase[1] = (wb_adr_i == OFS_ENERGY_B);
			clear_phase[2] = (wb_adr_i == OFS_ENERGY_C);
		end
	end

	aea_accumulator #(
		.ACC_WIDTH(ACC_W)
	) u_acc_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.step_i(step),
		.clear_i(clear_phase[0]),
		.creep_gate_enable_i(computation_mode_reg[CREEP_GATE_BIT]),
		.divider_i(energy_power_divider),
		.power_i(power_a),
		.energy_o(phase_a_active_energy)
	);

	aea_accumulator #(
		.ACC_WIDTH(ACC_W)
	) u_acc_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.step_i(step),
		.clear_i(clear_phase[1]),
		.creep_gate_enable_i(computation_mode_reg[CREEP_GATE_BIT]),
		.divider_i(energy_power_divider),
		.power_i(power_b),
		.energy_o(phase_b_active_energy)
	);

	aea_accumulator #(
		.ACC_WIDTH(ACC_W)
	) u_acc_c (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.step_i(step),
		.clear_i(clear_phase[2]),
		.creep_gate_enable_i(computation_mode_reg[CREEP_GATE_BIT]),
		.divider_i(energy_power_divider),
		.power_i(power_c),
		.energy_o(phase_c_active_energy)
	);

	// ----------------------------------------------------------------
	// Half-full event and interrupt.
	// ----------------------------------------------------------------
	assign half_now = {phase_c_active_energy[ENERGY_HALF_BIT],
		phase_b_active_energy[ENERGY_HALF_BIT], phase_a_active_energy[ENERGY_HALF_BIT]};
	assign half_evt = |(half_now ^ half_prev);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			half_prev <= '0;
		else
			half_prev <= half_now;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			half_full_status <= 1'b0;
		else if (half_evt)
			half_full_status <= 1'b1;
		else if (wr && wb_adr_i == OFS_INT_CLR && wb_sel_i[0] && wb_dat_i[HALF_FULL_BIT])
			half_full_status <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_n_o <= 1'b1;
		else
			irq_n_o <= !(half_full_status && energy_half_full_mask);
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	property p_step_period;
		@(posedge clk_i) disable iff (rst_i)
		step |=> !step [*3] ##1 step;
	endproperty
	a_step_period: assert property (p_step_period) else $error("Step spacing is not four clocks.");

	property p_half_event;
		@(posedge clk_i) disable iff (rst_i)
		half_evt |=> half_full_status ##1 (irq_n_o == !$past(energy_half_full_mask));
	endproperty
	a_half_event: assert property (p_half_event) else $error("Half-full change not flagged.");

	property p_irq_level;
		@(posedge clk_i) disable iff (rst_i)
		##1 irq_n_o == !$past(half_full_status && energy_half_full_mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt does not follow status.");

	property p_comb_b_zero;
		@(posedge clk_i) disable iff (rst_i)
		(computation_mode_reg[1:0] == 2'h1 || computation_mode_reg[1:0] == 2'h2) |=> power_b == '0;
	endproperty
	a_comb_b_zero: assert property (p_comb_b_zero) else $error("Phase B not zero in difference mode.");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("Acknowledge held longer than one cycle.");
endmodule
`default_nettype wire

/* sim/aea_energy_top_tb.sv */
// Self-checking bench for the active energy accumulator over its Wishbone port.
`timescale 1ns/1ps
`default_nettype none
module aea_energy_top_tb;
	import aea_pkg::*;
	// ------------------------------------------------------------
	// Signals and bench state.
	// ------------------------------------------------------------
	localparam int CEIL = 30000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADDR_W-1:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_n_o;
	aea_phase_s ph[3] = '{default: '0};
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	int v[3];
	int c[3];
	int dv[3] = '{1, 4, 255};
	int g_cur = 0;
	int g_pow = 0;
	logic [31:0] rd;

	always #50 clk_i = ~clk_i;

	aea_energy_top aea_energy_top_i (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.phase_a_i(ph[0]), .phase_b_i(ph[1]), .phase_c_i(ph[2]),
		.irq_n_o(irq_n_o)
	);

	// ------------------------------------------------------------
	// Checking, closing and bus tasks.
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == CEIL)
		begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		wb_xfer(1'b1, adr, d);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		wb_xfer(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask

	// ------------------------------------------------------------
	// Stimulus and expected energy.
	// ------------------------------------------------------------
	task automatic drive(input int n);
		@(posedge clk_i);
		for (int k = 0; k < 3; k++)
			ph[k] <= '{volt: 16'(v[k]), curr: 16'(c[k])};
		repeat (n) @(posedge clk_i);
		for (int k = 0; k < 3; k++)
			ph[k] <= '0;
		repeat (4) @(posedge clk_i);
	endtask

	function automatic longint scl(input longint x, input int g);
		return x + ((x * longint'(g)) >>> 12);
	endfunction

	function automatic longint cur(input int m, input int k);
		case (m)
			0: return c[k];
			1: return (k == 1) ? 0 : c[k] - c[1];
			2: return (k == 0) ? c[0] - c[1] : ((k == 1) ? 0 : c[2]);
			default: return 0;
		endcase
	endfunction

	task automatic run_check(input logic [7:0] mode, input int div, input int n);
		longint p;
		logic [40:0] acc;
		wr(OFS_COMP_MODE, {24'h0, mode});
		wr(OFS_DIVIDER, 32'(div));
		drive(n);
		for (int k = 0; k < 3; k++)
		begin
			p = scl(longint'(v[k]) * scl(cur(int'(mode[1:0]), k), g_cur), g_pow);
			if (mode[7] && p < 42 && p > -42)
				p = 0;
			if (div > 1)
				p = (p < 0) ? -((-p) / div) : p / div;
			acc = 41'(p * (n / 4));
			rd_chk(OFS_ENERGY_A + 8'(4 * k), {16'h0, acc[40:25]});
		end
	endtask

	// ------------------------------------------------------------
	// Test sequence.
	// ------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		check(32'(irq_n_o), 32'h1);
		for (int a = 0; a < 'h30; a += 4)
			rd_chk(8'(a), 32'h0);
		rd_chk(8'h40, 32'h0);
		wr(OFS_DIVIDER, 32'hff);
		rd_chk(OFS_DIVIDER, 32'hff);
		wr(OFS_ENERGY_A, 32'h1234);
		rd_chk(OFS_ENERGY_A, 32'h0);
		wr(OFS_LINE_MODE, 32'h40);
		rd_chk(OFS_LINE_MODE, 32'h40);
		v = '{16'sh4000, 16'sh4000, 16'sh4000};
		c = '{16'sh4000, -16'sh4000, 16'sh2000};
		run_check(8'h00, 0, 400);
		rd_chk(OFS_ENERGY_A, 32'h0);
		for (int i = 0; i < 3; i++)
			run_check(8'h00, dv[i], 400);
		c = '{16'sh4000, 16'sh1000, 16'sh2000};
		for (int m = 1; m < 4; m++)
			run_check(8'(m), 0, 400);
		g_cur = -2048;
		g_pow = 2047;
		wr(OFS_CURR_GAIN, 32'h800);
		for (int k = 0; k < 3; k++)
			wr(OFS_GAIN_A + 8'(4 * k), 32'h7ff);
		rd_chk(OFS_CURR_GAIN, 32'h800);
		rd_chk(OFS_GAIN_C, 32'h7ff);
		run_check(8'h01, 0, 400);
		g_cur = 0;
		wr(OFS_CURR_GAIN, 32'h0);
		run_check(8'h00, 0, 400);
		g_pow = 0;
		for (int k = 0; k < 3; k++)
			wr(OFS_GAIN_A + 8'(4 * k), 32'h0);
		v = '{16'sh0001, 16'sh0001, 16'sh0001};
		c = '{-16'sh0029, -16'sh002a, -16'sh0029};
		run_check(8'h80, 0, 4);
		run_check(8'h00, 0, 4);
		wr(OFS_INT_CLR, 32'h1);
		rd_chk(OFS_STATUS, 32'h0);
		wr(OFS_LINE_MODE, 32'h0);
		v = '{-16'sh8000, 16'sh0000, 16'sh0000};
		c = '{-16'sh8000, 16'sh0000, 16'sh0000};
		drive(4096);
		rd_chk(OFS_ENERGY_A, 32'h8000);
		rd_chk(OFS_ENERGY_A, 32'h8000);
		rd_chk(OFS_STATUS, 32'h1);
		check(32'(irq_n_o), 32'h1);
		wr(OFS_INT_EN, 32'h1);
		rd_chk(OFS_INT_EN, 32'h1);
		check(32'(irq_n_o), 32'h0);
		wr(OFS_INT_CLR, 32'h1);
		repeat (3) @(posedge clk_i);
		check(32'(irq_n_o), 32'h1);
		rd_chk(OFS_STATUS, 32'h0);
		wr(OFS_LINE_MODE, 32'h40);
		rd_chk(OFS_ENERGY_A, 32'h8000);
		rd_chk(OFS_ENERGY_A, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
